/* File: hdl/s2cr_pkg.sv */
// constants and register map of the second synthesizer control slice
// Functional notes
// - control bit 4 enables the secondary input doubler; resets to 1
// - four-bit pump gain code picks charge pump current, 0.4 to 6.4 mA
// - pump gain lives in control bits 3:0, read-write, resets to 0x8
// - 12-bit integer divider built from two consecutive byte registers
// - divider bits 11:8 in upper register bits 3:0, reset 0; 7:4 reserved
// - divider bits 7:0 fill the lower divider register, resets to 0x64
// - divider ratio equals code, codes 0 and 1 both give ratio 1
// - control bit 5 reserved read-write resetting 0; bits 7:6 reserved
package s2cr_pkg;
	localparam int ADDR_W = 8;
	localparam logic [7:0] OFS_CONTROL_B = 8'h48;
	localparam logic [7:0] OFS_DIV_HIGH = 8'h49;
	localparam logic [7:0] OFS_DIV_LOW = 8'h4a;
	localparam int POS_DOUBLER = 4;
	localparam int POS_RSV_RW = 5;
	localparam int POS_GAIN_LSB = 0;
	localparam int GAIN_W = 4;
	localparam int DIV_W = 12;
	localparam logic RST_DOUBLER = 1'b1;
	localparam logic RST_RSV_RW = 1'b0;
	localparam logic [3:0] RST_GAIN = 4'h8;
	localparam logic [3:0] RST_DIV_HIGH = 4'h0;
	localparam logic [7:0] RST_DIV_LOW = 8'h64;
	localparam logic [11:0] DIV_RATIO_MIN = 12'h001;
	localparam logic [12:0] RST_ICP = 13'h0af0;
	localparam logic [11:0] RST_RATIO = 12'h064;
	localparam logic [31:0] UNMAPPED_DATA = 32'h00000000;
	// pump current per code in microamps, unlisted codes 0 and 9 to 15 read as 0
	localparam logic [12:0] ICP_UA [0:15] = '{13'h0000, 13'h0190,
		13'h0320, 13'h0640, 13'h1900, 13'h04b0, 13'h07d0, 13'h0960,
		13'h0af0, 13'h0000, 13'h0000, 13'h0000, 13'h0000, 13'h0000,
		13'h0000, 13'h0000};
endpackage

/* File: hdl/s2cr_regs.sv */
// avalon-mm register slice for the second synthesizer controls
`timescale 1ns/10ps
module s2cr_regs (
	input wire logic CLK,
	input wire logic RST_N,
	input wire logic [7:0] ADDRESS,
	input wire logic READ,
	input wire logic WRITE,
	input wire logic [31:0] WRITEDATA,
	input wire logic [3:0] BYTEENABLE,
	output logic [31:0] READDATA,
	output logic WAITREQUEST,
	output logic SEC_REF_DOUBLER_EN,
	output logic [3:0] SYNTH2_PUMP_GAIN,
	output logic [12:0] SYNTH2_PUMP_CURRENT_UA,
	output logic [11:0] SYNTH2_INT_DIVIDER,
	output logic [11:0] SYNTH2_DIV_RATIO
);

	// one wait state per access, then one idle cycle
	typedef enum logic {
		bus_idle,
		bus_answer
	} s2cr_bus_t;

	// reset release
	logic rst_meta_q;
	logic rst_meta_d;
	logic rst_sync_q;
	logic rst_sync_d;

	// bus handshake
	s2cr_bus_t bus_state_q;
	s2cr_bus_t bus_state_d;
	logic wait_q;
	logic wait_d;
	logic wr_strobe;
	logic rd_strobe;
	logic wr_ctl;
	logic wr_hi;
	logic wr_lo;

	// read data
	logic [31:0] rdata_q;
	logic [31:0] rdata_d;
	logic [7:0] rbyte;

	// control register fields
	logic doubler_q;
	logic doubler_d;
	logic rsv_q;
	logic rsv_d;
	logic [3:0] gain_q;
	logic [3:0] gain_d;

	// divider bytes
	logic [3:0] div_hi_q;
	logic [3:0] div_hi_d;
	logic [7:0] div_lo_q;
	logic [7:0] div_lo_d;
	logic [11:0] div_full;

	// derived analog settings
	logic [12:0] icp_q;
	logic [12:0] icp_d;
	logic [11:0] ratio_q;
	logic [11:0] ratio_d;

	// one address compare shared by the three write decoders
	function automatic logic hits(input logic [7:0] a,
		input logic [7:0] ofs);
		logic h;
		h = (a == ofs);
		return h;
	endfunction

	// divide ratio of a code; the two lowest codes both divide by one
	function automatic logic [11:0] ratio_of(input logic [11:0] code);
		logic [11:0] r;
		r = code;
		if (code < s2cr_pkg::DIV_RATIO_MIN) begin
			r = s2cr_pkg::DIV_RATIO_MIN;
		end
		return r;
	endfunction

	// unmapped addresses and reserved bits other than control bit 5 read as zero
	function automatic logic [7:0] rd_byte(input logic [7:0] a,
		input logic dbl, input logic rsv, input logic [3:0] g,
		input logic [3:0] hi, input logic [7:0] lo);
		logic [7:0] r;
		r = 8'h00;
		unique case (a)
			s2cr_pkg::OFS_CONTROL_B: begin
				r[s2cr_pkg::POS_RSV_RW] = rsv;
				r[s2cr_pkg::POS_DOUBLER] = dbl;
				r[3:0] = g;
			end
			s2cr_pkg::OFS_DIV_HIGH: r[3:0] = hi;
			s2cr_pkg::OFS_DIV_LOW: r = lo;
			default: r = 8'h00;
		endcase
		return r;
	endfunction

	always_comb begin
		rst_meta_d = 1'b1;
		rst_sync_d = rst_meta_q;
	end

	// release is synchronous so no flop sees reset drop near an edge
	// the second flop alone feeds the rest of the design
	always_ff @(posedge CLK or negedge RST_N) begin
		if (!RST_N) begin
			rst_meta_q <= 1'b0;
			rst_sync_q <= 1'b0;
		end else begin
			rst_meta_q <= rst_meta_d;
			rst_sync_q <= rst_sync_d;
		end
	end

	// bus handshake
	always_comb begin
		bus_state_d = bus_state_q;
		wait_d = 1'b1;
		unique case (bus_state_q)
			bus_idle: begin
				// a request seen here is answered on the next edge
				if (READ || WRITE) begin
					bus_state_d = bus_answer;
					wait_d = 1'b0;
				end
			end
			bus_answer: begin
				// the master drops its request here, so rest one cycle
				bus_state_d = bus_idle;
				wait_d = 1'b1;
			end
		endcase
	end

	always_ff @(posedge CLK or negedge rst_sync_q) begin
		if (!rst_sync_q) begin
			bus_state_q <= bus_idle;
			wait_q <= 1'b1;
		end else begin
			bus_state_q <= bus_state_d;
			wait_q <= wait_d;
		end
	end

	// a write lands only on the edge where waitrequest is seen low
	assign wr_strobe = (bus_state_q == bus_answer) && WRITE &&
		BYTEENABLE[0];
	assign rd_strobe = (bus_state_q == bus_idle) && READ;
	assign wr_ctl = wr_strobe && hits(ADDRESS, s2cr_pkg::OFS_CONTROL_B);
	assign wr_hi = wr_strobe && hits(ADDRESS, s2cr_pkg::OFS_DIV_HIGH);
	assign wr_lo = wr_strobe && hits(ADDRESS, s2cr_pkg::OFS_DIV_LOW);

	// read data are registered, hence the single wait state
	always_comb begin
		rbyte = rd_byte(ADDRESS, doubler_q, rsv_q, gain_q,
			div_hi_q, div_lo_q);
		rdata_d = rdata_q;
		if (rd_strobe) begin
			rdata_d = s2cr_pkg::UNMAPPED_DATA;
			rdata_d[7:0] = rbyte;
		end
	end

	always_ff @(posedge CLK or negedge rst_sync_q) begin
		if (!rst_sync_q) begin
			rdata_q <= s2cr_pkg::UNMAPPED_DATA;
		end else begin
			rdata_q <= rdata_d;
		end
	end

	// doubler enable
	always_comb begin
		doubler_d = doubler_q;
		if (wr_ctl) begin
			doubler_d = WRITEDATA[s2cr_pkg::POS_DOUBLER];
		end
	end

	always_ff @(posedge CLK or negedge rst_sync_q) begin
		if (!rst_sync_q) begin
			doubler_q <= s2cr_pkg::RST_DOUBLER;
		end else begin
			doubler_q <= doubler_d;
		end
	end

	// reserved bit kept only so software reads back what it wrote
	always_comb begin
		rsv_d = rsv_q;
		if (wr_ctl) begin
			rsv_d = WRITEDATA[s2cr_pkg::POS_RSV_RW];
		end
	end

	always_ff @(posedge CLK or negedge rst_sync_q) begin
		if (!rst_sync_q) begin
			rsv_q <= s2cr_pkg::RST_RSV_RW;
		end else begin
			rsv_q <= rsv_d;
		end
	end

	// pump gain code; unlisted codes are stored and read back as written
	always_comb begin
		gain_d = gain_q;
		if (wr_ctl) begin
			gain_d = WRITEDATA[3:0];
		end
	end

	always_ff @(posedge CLK or negedge rst_sync_q) begin
		if (!rst_sync_q) begin
			gain_q <= s2cr_pkg::RST_GAIN;
		end else begin
			gain_q <= gain_d;
		end
	end

	// divider bits 11:8; the reserved upper nibble is not stored
	always_comb begin
		div_hi_d = div_hi_q;
		if (wr_hi) begin
			div_hi_d = WRITEDATA[3:0];
		end
	end

	always_ff @(posedge CLK or negedge rst_sync_q) begin
		if (!rst_sync_q) begin
			div_hi_q <= s2cr_pkg::RST_DIV_HIGH;
		end else begin
			div_hi_q <= div_hi_d;
		end
	end

	// divider bits 7:0
	always_comb begin
		div_lo_d = div_lo_q;
		if (wr_lo) begin
			div_lo_d = WRITEDATA[7:0];
		end
	end

	always_ff @(posedge CLK or negedge rst_sync_q) begin
		if (!rst_sync_q) begin
			div_lo_q <= s2cr_pkg::RST_DIV_LOW;
		end else begin
			div_lo_q <= div_lo_d;
		end
	end

	// bytes land one at a time, so a mixed value shows in between
	assign div_full = {div_hi_q, div_lo_q};

	// pump current in microamps; unlisted codes give zero, not a guess
	always_comb begin
		icp_d = s2cr_pkg::ICP_UA[gain_q];
	end

	always_ff @(posedge CLK or negedge rst_sync_q) begin
		if (!rst_sync_q) begin
			icp_q <= s2cr_pkg::RST_ICP;
		end else begin
			icp_q <= icp_d;
		end
	end

	// clamped divide ratio
	always_comb begin
		ratio_d = ratio_of(div_full);
	end

	always_ff @(posedge CLK or negedge rst_sync_q) begin
		if (!rst_sync_q) begin
			ratio_q <= s2cr_pkg::RST_RATIO;
		end else begin
			ratio_q <= ratio_d;
		end
	end

	// every output below is a flop or a concatenation of flops
	assign READDATA = rdata_q;
	assign WAITREQUEST = wait_q;
	assign SEC_REF_DOUBLER_EN = doubler_q;
	assign SYNTH2_PUMP_GAIN = gain_q;
	assign SYNTH2_PUMP_CURRENT_UA = icp_q;
	assign SYNTH2_INT_DIVIDER = div_full;
	assign SYNTH2_DIV_RATIO = ratio_q;
endmodule

/* File: sim/s2cr_regs_checker.sv */
// assertions on the second synthesizer control slice ports
`timescale 1ns/10ps
module s2cr_chk (
	input wire logic CLK,
	input wire logic RST_N,
	input wire logic READ,
	input wire logic WRITE,
	input wire logic WAITREQUEST,
	input wire logic SEC_REF_DOUBLER_EN,
	input wire logic [7:0] ADDRESS,
	input wire logic [31:0] WRITEDATA,
	input wire logic [31:0] READDATA,
	input wire logic [3:0] BYTEENABLE,
	input wire logic [3:0] SYNTH2_PUMP_GAIN,
	input wire logic [12:0] SYNTH2_PUMP_CURRENT_UA,
	input wire logic [11:0] SYNTH2_INT_DIVIDER,
	input wire logic [11:0] SYNTH2_DIV_RATIO
);
	default clocking @(posedge CLK); endclocking
	default disable iff (!RST_N);
	wire logic wr = WRITE && !WAITREQUEST && BYTEENABLE[0];
	property p_ack; !WAITREQUEST |-> $past(READ || WRITE) ##1 WAITREQUEST; endproperty
	a_ack: assert property (p_ack) else $error("ack without request");
	property p_ctl; wr && ADDRESS == 8'h48 |=> SYNTH2_PUMP_GAIN ==
		$past(WRITEDATA[3:0]) && SEC_REF_DOUBLER_EN == $past(WRITEDATA[4]); endproperty
	a_ctl: assert property (p_ctl) else $error("control write lost");
	property p_hi; wr && ADDRESS == 8'h49 |=> SYNTH2_INT_DIVIDER[11:8] ==
		$past(WRITEDATA[3:0]); endproperty
	a_hi: assert property (p_hi) else $error("divider high lost");
	property p_lo; wr && ADDRESS == 8'h4a |=> SYNTH2_INT_DIVIDER[7:0] ==
		$past(WRITEDATA[7:0]); endproperty
	a_lo: assert property (p_lo) else $error("divider low lost");
	property p_rd; READ && !WAITREQUEST && ADDRESS == 8'h4a |->
		READDATA == {24'h0, SYNTH2_INT_DIVIDER[7:0]}; endproperty
	a_rd: assert property (p_rd) else $error("divider read wrong");
	property p_rat; SYNTH2_DIV_RATIO == ($past(SYNTH2_INT_DIVIDER) < 12'h002 ?
		12'h001 : $past(SYNTH2_INT_DIVIDER)); endproperty
	a_rat: assert property (p_rat) else $error("ratio wrong");
	property p_cur; $past(SYNTH2_PUMP_GAIN) == 4'h4 |->
		SYNTH2_PUMP_CURRENT_UA == 13'h1900; endproperty
	a_cur: assert property (p_cur) else $error("pump current wrong");
	property p_rsv; READ && !WAITREQUEST && ADDRESS == 8'h48 |->
		READDATA[31:6] == 26'h0; endproperty
	a_rsv: assert property (p_rsv) else $error("reserved bits read");
endmodule
bind s2cr_regs s2cr_chk u_chk (.*);

/* File: sim/s2cr_regs_tb.sv */
// bench for the second synthesizer control slice
`timescale 1ns/10ps
module s2cr_regs_tb;
	logic CLK = 0, RST_N = 0, READ = 0, WRITE = 0, WAITREQUEST, SEC_REF_DOUBLER_EN;
	logic [7:0] ADDRESS = 0;
	logic [31:0] WRITEDATA = 0, READDATA, rd;
	logic [3:0] BYTEENABLE = 0, SYNTH2_PUMP_GAIN;
	logic [12:0] SYNTH2_PUMP_CURRENT_UA;
	logic [11:0] SYNTH2_INT_DIVIDER, SYNTH2_DIV_RATIO;
	int fail_count = 0, tests_run = 0;
	int ua[8] = '{400, 800, 1600, 6400, 1200, 2000, 2400, 2800};
	s2cr_regs uut (
		.CLK(CLK),
		.RST_N(RST_N),
		.ADDRESS(ADDRESS),
		.READ(READ),
		.WRITE(WRITE),
		.WRITEDATA(WRITEDATA),
		.BYTEENABLE(BYTEENABLE),
		.READDATA(READDATA),
		.WAITREQUEST(WAITREQUEST),
		.SEC_REF_DOUBLER_EN(SEC_REF_DOUBLER_EN),
		.SYNTH2_PUMP_GAIN(SYNTH2_PUMP_GAIN),
		.SYNTH2_PUMP_CURRENT_UA(SYNTH2_PUMP_CURRENT_UA),
		.SYNTH2_INT_DIVIDER(SYNTH2_INT_DIVIDER),
		.SYNTH2_DIV_RATIO(SYNTH2_DIV_RATIO)
	);
	always #20 CLK = ~CLK;
	task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
		READ <= !w;
		WRITE <= w;
		ADDRESS <= a;
		WRITEDATA <= d;
		BYTEENABLE <= {3'h0, w};
		do @(posedge CLK); while (WAITREQUEST !== 1'b0);
		rd = READDATA;
		READ <= 0;
		WRITE <= 0;
		// derived outputs lag the write by one more edge
		repeat (2) @(posedge CLK);
	endtask
	task automatic chk(input string s, input logic [31:0] e, input logic [31:0] g);
		tests_run++;
		if (g !== e) begin
			fail_count++;
			$display("CHECK FAILED %s exp %h got %h", s, e, g);
		end
	endtask
	task automatic rc(input logic [7:0] a, input logic [31:0] e);
		bus(0, a, 0);
		chk("readdata", e, rd);
	endtask
	task final_report;
		$display("checks %0d mismatches %0d", tests_run, fail_count);
		if (fail_count == 0 && tests_run > 0) $display("Result: passed");
		else $display("Result: failed");
		$finish;
	endtask
	initial begin
		#200000;
		fail_count++;
		final_report;
	end
	initial begin
		repeat (8) @(posedge CLK);
		RST_N <= 1;
		repeat (3) @(posedge CLK);
		rc(8'h48, 32'h18);
		chk("doubler", 32'h1, SEC_REF_DOUBLER_EN);
		chk("gain", 32'h8, SYNTH2_PUMP_GAIN);
		chk("divider", 32'h64, SYNTH2_INT_DIVIDER);
		rc(8'h49, 32'h0);
		rc(8'h4a, 32'h64);
		rc(8'h4b, 32'h0);
		chk("current", 32'd2800, SYNTH2_PUMP_CURRENT_UA);
		bus(1, 8'h48, 32'h3f);
		rc(8'h48, 32'h3f);
		for (int i = 0; i < 8; i++) begin
			bus(1, 8'h48, i + 1);
			chk("current", ua[i], SYNTH2_PUMP_CURRENT_UA);
		end
		chk("doubler", 32'h0, SEC_REF_DOUBLER_EN);
		chk("gain", 32'h8, SYNTH2_PUMP_GAIN);
		bus(1, 8'h49, 32'h0f);
		bus(1, 8'h4a, 32'hff);
		rc(8'h49, 32'h0f);
		chk("ratio", 32'hfff, SYNTH2_DIV_RATIO);
		bus(1, 8'h49, 32'h0);
		bus(1, 8'h4a, 32'h1);
		chk("ratio", 32'h1, SYNTH2_DIV_RATIO);
		bus(1, 8'h4a, 32'h0);
		bus(1, 8'h4b, 32'h55);
		chk("divider", 32'h0, SYNTH2_INT_DIVIDER);
		chk("ratio", 32'h1, SYNTH2_DIV_RATIO);
		final_report;
	end
endmodule
